// >>> servo_status_output_mapper.sv
// status output mapper: builds motion flags and routes them to 3 outputs.
// assumes speeds in signed rpm, deviation as magnitude in command units,
// and a parameter write port already decoded from the object dictionary.
`timescale 1ns/100ps
`default_nettype none
`include "status_output_defines.svh"
module servo_status_output_mapper #(
    parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_sys_rst,
    input  wire status_output_pkg::param_wr_t   i_param,
    output logic [15:0]                         o_param_rdata,
    input  wire logic [15:0]                    i_param_rindex,
    input  wire status_output_pkg::ext_flags_t  i_flags,
    input  wire logic                           i_pos_cmd_active,
    input  wire logic [31:0]                    i_pos_deviation,
    input  wire logic signed [15:0]             i_speed_actual,
    input  wire logic signed [15:0]             i_speed_command,
    input  wire logic [2:0]                     i_master_outputs,
    output logic                                o_zero_speed_detect_flag,
    output logic                                o_speed_match_flag,
    output logic                                o_positioning_done_flag,
    output logic [2:0]                          o_outputs
);
    import status_output_pkg::*;

    // a zero divider would never count a millisecond
    if (CYCLES_PER_MS < 1) begin : g_bad_cycles
        $error("CYCLES_PER_MS must be at least 1");
    end

    logic [7:0]  out_sel [3];
    logic [15:0] positioning_window;
    logic [15:0] positioning_done_mode;
    logic [15:0] positioning_done_delay;
    logic [15:0] zero_speed_threshold;
    logic [15:0] speed_match_range;

    function automatic logic [15:0] abs16(input logic signed [16:0] v);
        logic signed [16:0] a;
        a = (v < 0) ? -v : v;
        return (a > 17'sd65535) ? 16'hFFFF : a[15:0];
    endfunction

    function automatic logic [16:0] lo_edge(input logic [15:0] t);
        return (t > `HYST_RPM) ? {1'b0, t - `HYST_RPM} : 17'h0_0000;
    endfunction

    function automatic logic [16:0] hi_edge(input logic [15:0] t);
        return {1'b0, t} + {1'b0, `HYST_RPM};
    endfunction

    // writes apply on the next edge, no disable needed
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            out_sel[0]             <= `RST_SEL;
            out_sel[1]             <= `RST_SEL;
            out_sel[2]             <= `RST_SEL;
            positioning_window     <= `RST_POS_WINDOW;
            positioning_done_mode  <= `RST_POS_MODE;
            positioning_done_delay <= `RST_POS_DELAY;
            zero_speed_threshold   <= `RST_ZERO_THR;
            speed_match_range      <= `RST_MATCH_RANGE;
        end else if (i_param.wr) begin
            unique case (i_param.index)
                `IDX_OUT1_SEL:    out_sel[0] <= i_param.data[7:0];
                `IDX_OUT2_SEL:    out_sel[1] <= i_param.data[7:0];
                `IDX_OUT3_SEL:    out_sel[2] <= i_param.data[7:0];
                `IDX_POS_WINDOW:  positioning_window <= i_param.data;
                `IDX_POS_MODE:    positioning_done_mode <= i_param.data;
                `IDX_POS_DELAY:   positioning_done_delay <= i_param.data;
                `IDX_ZERO_THR:    zero_speed_threshold <= i_param.data;
                `IDX_MATCH_RANGE: speed_match_range <= i_param.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_param_rdata <= 16'h0000;
        end else begin
            unique case (i_param_rindex)
                `IDX_OUT1_SEL:    o_param_rdata <= {8'h00, out_sel[0]};
                `IDX_OUT2_SEL:    o_param_rdata <= {8'h00, out_sel[1]};
                `IDX_OUT3_SEL:    o_param_rdata <= {8'h00, out_sel[2]};
                `IDX_POS_WINDOW:  o_param_rdata <= positioning_window;
                `IDX_POS_MODE:    o_param_rdata <= positioning_done_mode;
                `IDX_POS_DELAY:   o_param_rdata <= positioning_done_delay;
                `IDX_ZERO_THR:    o_param_rdata <= zero_speed_threshold;
                `IDX_MATCH_RANGE: o_param_rdata <= speed_match_range;
                default:          o_param_rdata <= 16'h0000;
            endcase
        end
    end

    // zero-speed: magnitude with hysteresis, so no chatter at the edge
    logic [15:0] speed_mag;
    logic [15:0] match_err;
    assign speed_mag = abs16({i_speed_actual[15], i_speed_actual});
    assign match_err = abs16({i_speed_command[15], i_speed_command}
                             - {i_speed_actual[15], i_speed_actual});

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_zero_speed_detect_flag <= 1'b0;
        end else if ({1'b0, speed_mag} < lo_edge(zero_speed_threshold)) begin
            o_zero_speed_detect_flag <= 1'b1;
        end else if ({1'b0, speed_mag}
                     > hi_edge(zero_speed_threshold)) begin
            o_zero_speed_detect_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_speed_match_flag <= 1'b0;
        end else if ({1'b0, match_err} < lo_edge(speed_match_range)) begin
            o_speed_match_flag <= 1'b1;
        end else if ({1'b0, match_err}
                     > hi_edge(speed_match_range)) begin
            o_speed_match_flag <= 1'b0;
        end
    end

    // positioning delay timer, restarted by each new position command
    pd_state_t   pd_state;
    logic [31:0] ms_div;
    logic [15:0] ms_count;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_pos_cmd_active) begin
            pd_state <= PD_MOVING;
            ms_div   <= 32'h0000_0000;
            ms_count <= 16'h0000;
        end else begin
            unique case (pd_state)
                PD_MOVING: pd_state <= PD_WAIT;
                PD_WAIT: begin
                    if (ms_count >= positioning_done_delay) begin
                        pd_state <= PD_EXPIRED;
                    end else if (ms_div == 32'(CYCLES_PER_MS - 1)) begin
                        ms_div   <= 32'h0000_0000;
                        ms_count <= ms_count + 16'h0001;
                    end else begin
                        ms_div <= ms_div + 32'h0000_0001;
                    end
                end
                PD_EXPIRED: pd_state <= PD_EXPIRED;
                default: pd_state <= PD_MOVING;
            endcase
        end
    end

    logic in_window;
    logic idle;
    logic delay_zero;
    logic next_pos_done;
    assign in_window  = i_pos_deviation < {16'h0000, positioning_window};
    assign idle       = !i_pos_cmd_active;
    assign delay_zero = positioning_done_delay == 16'h0000;

    always_comb begin
        unique case (positioning_done_mode[2:0])
            3'd0: next_pos_done = in_window;
            3'd1: next_pos_done = idle && in_window;
            3'd2: next_pos_done = idle && in_window
                                  && o_zero_speed_detect_flag;
            // on only inside the delay window; 0 means until next command
            3'd3: next_pos_done = idle && in_window
                                  && (delay_zero
                                      || pd_state != PD_EXPIRED);
            3'd4: next_pos_done = idle && in_window
                                  && (delay_zero
                                      || pd_state == PD_EXPIRED);
            default: next_pos_done = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_positioning_done_flag <= 1'b0;
        end else begin
            o_positioning_done_flag <= next_pos_done;
        end
    end

    // unlisted codes (software's fault) select nothing: source false
    function automatic logic source_of(input logic [6:0] code);
        unique case ({1'b0, code})
            FN_ALARM:    return i_flags.alarm_flag;
            FN_READY:    return i_flags.servo_ready;
            FN_BRAKE:    return i_flags.brake_released_flag;
            FN_POS_DONE: return o_positioning_done_flag;
            FN_SPEED_REACHED_FLAG: return i_flags.speed_reached_flag;
            FN_TORQUE:   return i_flags.torque_limit_flag;
            FN_ZERO_SPD: return o_zero_speed_detect_flag;
            FN_MATCH:    return o_speed_match_flag;
            FN_POS_CMD:  return i_pos_cmd_active;
            FN_VEL_LIM:  return i_flags.vel_limit;
            FN_VEL_CMD:  return i_flags.vel_cmd_active;
            FN_SERVO_ST: return i_flags.servo_state_flag;
            FN_COMPARE:  return i_flags.position_compare_flag;
            FN_HOMED:    return i_flags.homing_done;
            default:     return 1'b0;
        endcase
    endfunction

    logic all_master;
    assign all_master = (out_sel[0] == 8'h00) && (out_sel[1] == 8'h00)
                        && (out_sel[2] == 8'h00);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_outputs <= 3'b000;
        end else if (all_master) begin
            o_outputs <= i_master_outputs;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (out_sel[i][`POLARITY_BIT]) begin
                    o_outputs[i] <= source_of(out_sel[i][6:0]);
                end else begin
                    o_outputs[i] <= !source_of(out_sel[i][6:0]);
                end
            end
        end
    end

    a_master_passthru: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        all_master |=> o_outputs == $past(i_master_outputs))
        else $error("master outputs not passed through");
    a_open_active_low: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (!all_master && out_sel[0] == 8'h07 && o_zero_speed_detect_flag)
        |=> !o_outputs[0])
        else $error("open code output not low");
    a_close_active_hi: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (!all_master && out_sel[0] == 8'h87 && o_zero_speed_detect_flag)
        |=> o_outputs[0])
        else $error("close code output not high");
    a_zero_speed_set: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ({1'b0, speed_mag} < lo_edge(zero_speed_threshold))
        |=> o_zero_speed_detect_flag)
        else $error("zero speed flag not set");
    a_zero_speed_hold: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (o_zero_speed_detect_flag && speed_mag <= zero_speed_threshold)
        |=> o_zero_speed_detect_flag)
        else $error("zero speed flag dropped inside band");
    a_match_clear: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ({1'b0, match_err} > hi_edge(speed_match_range))
        |=> !o_speed_match_flag)
        else $error("speed match flag not cleared");
    a_mode0_window: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (positioning_done_mode == 16'h0000 && in_window)
        |=> o_positioning_done_flag)
        else $error("mode 0 flag not set in window");
    a_cmd_clears_done: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (positioning_done_mode == 16'h0001 && i_pos_cmd_active)
        |=> !o_positioning_done_flag)
        else $error("done flag on during command");
    a_param_write: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_param.wr && i_param.index == `IDX_POS_WINDOW)
        |=> positioning_window == $past(i_param.data))
        else $error("window write not applied");
    a_zero_speed_clear: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ({1'b0, speed_mag} > hi_edge(zero_speed_threshold))
        |=> !o_zero_speed_detect_flag)
        else $error("zero speed flag not cleared");
    a_match_set: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        ({1'b0, match_err} < lo_edge(speed_match_range))
        |=> o_speed_match_flag)
        else $error("speed match flag not set");
    a_mode1_idle: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (positioning_done_mode == 16'h0001 && idle && in_window)
        |=> o_positioning_done_flag)
        else $error("mode 1 flag not set when idle");
    a_mode2_zero: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (positioning_done_mode == 16'h0002 && !o_zero_speed_detect_flag)
        |=> !o_positioning_done_flag)
        else $error("mode 2 flag on without zero speed");
    a_mode3_expired: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (positioning_done_mode == 16'h0003 && !delay_zero
         && pd_state == PD_EXPIRED)
        |=> !o_positioning_done_flag)
        else $error("mode 3 flag on after delay");
    a_mode4_wait: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (positioning_done_mode == 16'h0004 && !delay_zero
         && pd_state != PD_EXPIRED)
        |=> !o_positioning_done_flag)
        else $error("mode 4 flag on during delay");
    a_delay_zero_hold: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (positioning_done_mode == 16'h0004 && delay_zero && idle
         && in_window)
        |=> o_positioning_done_flag)
        else $error("zero delay flag not held on");
    a_outside_window: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        !in_window |=> !o_positioning_done_flag)
        else $error("done flag on outside window");
endmodule // servo_status_output_mapper
`default_nettype wire

// >>> status_output_defines.svh
// constants of the servo status output mapper: parameter indices,
// reset values, hysteresis, polarity bit and timing counts.
// assumes a 50 MHz control clock.
// What this block does
// - each output has an 8-bit function select, range 00h-FFh, reset 00h.
// - function codes pick alarm, ready, brake, motion and other sources.
// - normally-open code drives the output low while the source is true.
// - normally-close code is open code with bit 7 set; output driven high.
// - all three selects zero: master bits 16-18 drive outputs one to three.
// - positioning window 0-10000 command units, default 20.
// - done mode 0-4, default 1; mode 0 ignores command activity.
// - mode 1 needs no command; mode 2 also needs zero-speed flag.
// - mode 3 flag on only during the delay time after command stop.
// - mode 4 waits the delay after command stop, then evaluates.
// - delay 0-15000 ms, default 0; 0 keeps flag on until next command.
// - delay 1-15000, mode 4: flag off during delay, on after, off at next command.
// - zero-speed flag when speed below threshold 1-2000 rpm, default 50.
// - zero-speed compares magnitude only, same for both directions.
// - zero-speed uses a 10 rpm hysteresis band.
// - speed match flag when speed error below range 10-2000, default 50.
// - speed match turns on below range-10, off above range+10.
`ifndef STATUS_OUTPUT_DEFINES_SVH
`define STATUS_OUTPUT_DEFINES_SVH
`define IDX_OUT1_SEL      16'h2410
`define IDX_OUT2_SEL      16'h2411
`define IDX_OUT3_SEL      16'h2412
`define IDX_POS_WINDOW    16'h2431
`define IDX_POS_MODE      16'h2432
`define IDX_POS_DELAY     16'h2433
`define IDX_ZERO_THR      16'h2434
`define IDX_MATCH_RANGE   16'h2435
`define RST_SEL           8'h00
`define RST_POS_WINDOW    16'h0014
`define RST_POS_MODE      16'h0001
`define RST_POS_DELAY     16'h0000
`define RST_ZERO_THR      16'h0032
`define RST_MATCH_RANGE   16'h0032
`define HYST_RPM          16'h000A
`define POLARITY_BIT      7
`define CLK_HZ            50000000
`define DELAY_UNIT_MS     1
`define CYCLES_PER_MS     ((`CLK_HZ / 1000) * `DELAY_UNIT_MS)
`endif

// >>> status_output_pkg.sv
// types of the servo status output mapper.
package status_output_pkg;
    typedef enum logic [7:0] {
        FN_MASTER   = 8'h00,
        FN_ALARM    = 8'h01,
        FN_READY    = 8'h02,
        FN_BRAKE    = 8'h03,
        FN_POS_DONE = 8'h04,
        FN_SPEED_REACHED_FLAG = 8'h05,
        FN_TORQUE   = 8'h06,
        FN_ZERO_SPD = 8'h07,
        FN_MATCH    = 8'h08,
        FN_POS_CMD  = 8'h0B,
        FN_VEL_LIM  = 8'h0D,
        FN_VEL_CMD  = 8'h0F,
        FN_SERVO_ST = 8'h12,
        FN_COMPARE  = 8'h14,
        FN_HOMED    = 8'h22
    } func_code_t;
    typedef enum logic [1:0] {
        PD_MOVING  = 2'b00,
        PD_WAIT    = 2'b01,
        PD_EXPIRED = 2'b10
    } pd_state_t;
    // status inputs produced elsewhere in the drive
    typedef struct packed {
        logic alarm_flag;
        logic servo_ready;
        logic brake_released_flag;
        logic speed_reached_flag;
        logic torque_limit_flag;
        logic vel_limit;
        logic vel_cmd_active;
        logic servo_state_flag;
        logic position_compare_flag;
        logic homing_done;
    } ext_flags_t;
    // parameter write port, one index per cycle
    typedef struct packed {
        logic        wr;
        logic [15:0] index;
        logic [15:0] data;
    } param_wr_t;
endpackage

// >>> status_master_model.sv
// fieldbus master model: parameter writes and direct output bits.
// assumes the mapper samples its inputs on the rising edge of i_clk.
`timescale 1ns/100ps
`default_nettype none
module status_master_model
    import status_output_pkg::*;
(
    input  wire logic                         i_clk,
    output status_output_pkg::param_wr_t      o_param,
    output logic [2:0]                        o_master_outputs
);
    initial begin
        o_param          = '0;
        o_master_outputs = 3'h0;
    end
    // callers pass any parameter index and 16-bit value, not only function codes
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        @(negedge i_clk);
        o_param = '{1'b1, idx, d};
        @(negedge i_clk);
        // released lines show no stale value
        o_param = '{1'b0, ~idx, ~d};
    endtask
    task automatic set_master(input logic [2:0] b);
        @(negedge i_clk);
        o_master_outputs = b;
    endtask
endmodule // status_master_model
`default_nettype wire

// >>> servo_status_output_mapper_tb_top.sv
// self-checking bench of the status output mapper.
// assumes CYCLES_PER_MS shortened to 4; inputs change at falling edges.
`timescale 1ns/100ps
`default_nettype none
`include "status_output_defines.svh"
module servo_status_output_mapper_tb_top;
    import status_output_pkg::*;
    logic               i_clk;
    logic               i_sys_rst;
    param_wr_t          prm;
    logic [15:0]        rdata;
    logic [15:0]        rindex;
    ext_flags_t         flags;
    logic               cmd;
    logic [31:0]        dev;
    logic signed [15:0] spd;
    logic signed [15:0] scmd;
    logic [2:0]         mbits;
    logic [2:0]         outs;
    logic               zero_flag;
    logic               vm;
    logic               pd;
    int                 err_count;
    int                 n_tests;
    logic [7:0]  codes [10] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06,
                                8'h0D, 8'h0F, 8'h12, 8'h14, 8'h22};
    logic [15:0] ri [8] = '{`IDX_OUT1_SEL, `IDX_OUT2_SEL, `IDX_OUT3_SEL,
        `IDX_POS_WINDOW, `IDX_POS_MODE, `IDX_POS_DELAY, `IDX_ZERO_THR,
        `IDX_MATCH_RANGE};
    logic [15:0] re [8] = '{16'h0000, 16'h0000, 16'h0000,
        `RST_POS_WINDOW, `RST_POS_MODE, `RST_POS_DELAY, `RST_ZERO_THR,
        `RST_MATCH_RANGE};
    logic signed [15:0] zs [5] = '{16'sd0, 16'sd55, 16'sd61, -16'sd45,
                                   -16'sd39};
    logic signed [15:0] ms [5] = '{16'sd100, 16'sd155, 16'sd161, 16'sd141,
                                   16'sd139};
    logic        hx [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

    servo_status_output_mapper #(.CYCLES_PER_MS(4)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_param(prm),
        .o_param_rdata(rdata), .i_param_rindex(rindex), .i_flags(flags),
        .i_pos_cmd_active(cmd), .i_pos_deviation(dev),
        .i_speed_actual(spd), .i_speed_command(scmd),
        .i_master_outputs(mbits), .o_zero_speed_detect_flag(zero_flag),
        .o_speed_match_flag(vm), .o_positioning_done_flag(pd),
        .o_outputs(outs));
    status_master_model pm (.i_clk(i_clk), .o_param(prm),
                            .o_master_outputs(mbits));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        pm.wr(idx, d);
        tick(3);
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        final_report;
    end
    initial begin
        err_count = 0;
        n_tests = 0;
        i_sys_rst = 1'b1;
        rindex = 16'h0000;
        flags = '0;
        cmd = 1'b0;
        dev = 32'h0000_0005;
        spd = 16'sd0;
        scmd = 16'sd0;
        tick(8);
        i_sys_rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rindex = ri[i];
            tick(1);
            chk(rdata, re[i]);
        end
        $display("test reset values done");
        pm.set_master(3'b101);
        tick(3);
        chk(16'(outs), 16'h0005);
        pm.set_master(3'b010);
        tick(3);
        chk(16'(outs), 16'h0002);
        $display("test master control done");
        for (int i = 0; i < 10; i++) begin
            flags = 10'h200 >> i;
            wr(`IDX_OUT1_SEL, 16'(codes[i]));
            chk(16'(outs[0]), 16'h0000);
            wr(`IDX_OUT1_SEL, 16'(codes[i] | 8'h80));
            chk(16'(outs[0]), 16'h0001);
            flags = '0;
            tick(3);
            chk(16'(outs[0]), 16'h0000);
        end
        wr(`IDX_OUT1_SEL, 16'h000B);
        cmd = 1'b1;
        tick(3);
        chk(16'(outs[0]), 16'h0000);
        cmd = 1'b0;
        $display("test function codes done");
        for (int i = 0; i < 5; i++) begin
            spd = zs[i];
            scmd = zs[i];
            tick(3);
            chk(16'(zero_flag), 16'(hx[i]));
        end
        scmd = 16'sd100;
        for (int i = 0; i < 5; i++) begin
            spd = ms[i];
            tick(3);
            chk(16'(vm), 16'(hx[i]));
        end
        spd = 16'sd0;
        scmd = 16'sd0;
        $display("test speed flags done");
        wr(`IDX_OUT1_SEL, 16'h0087);
        chk(16'(outs[0]), 16'h0001);
        wr(`IDX_OUT1_SEL, 16'h0007);
        chk(16'(outs[0]), 16'h0000);
        wr(`IDX_OUT3_SEL, 16'h0188);
        rindex = `IDX_OUT3_SEL;
        tick(1);
        chk(rdata, 16'h0088);
        chk(16'(outs[2]), 16'h0001);
        spd = 16'sd100;
        tick(3);
        chk(16'(outs[0]), 16'h0001);
        chk(16'(outs[2]), 16'h0000);
        spd = 16'sd0;
        $display("test flag routing done");
        wr(`IDX_OUT2_SEL, 16'h0084);
        wr(`IDX_OUT1_SEL, 16'h0000);
        pm.set_master(3'b000);
        tick(3);
        chk(16'(outs[0]), 16'h0001);
        wr(`IDX_POS_MODE, 16'h0000);
        cmd = 1'b1;
        tick(3);
        chk(16'(pd), 16'h0001);
        chk(16'(outs[1]), 16'h0001);
        dev = 32'h0000_0014;
        tick(3);
        chk(16'(pd), 16'h0000);
        dev = 32'h0000_0005;
        wr(`IDX_POS_MODE, 16'h0001);
        chk(16'(pd), 16'h0000);
        cmd = 1'b0;
        tick(3);
        chk(16'(pd), 16'h0001);
        wr(`IDX_POS_MODE, 16'h0002);
        spd = 16'sd100;
        tick(4);
        chk(16'(pd), 16'h0000);
        spd = 16'sd0;
        tick(4);
        chk(16'(pd), 16'h0001);
        wr(`IDX_POS_WINDOW, 16'h0005);
        chk(16'(pd), 16'h0000);
        wr(`IDX_POS_WINDOW, 16'h0014);
        wr(`IDX_POS_DELAY, 16'h0002);
        wr(`IDX_POS_MODE, 16'h0003);
        cmd = 1'b1;
        tick(3);
        chk(16'(pd), 16'h0000);
        cmd = 1'b0;
        tick(3);
        chk(16'(pd), 16'h0001);
        tick(12);
        chk(16'(pd), 16'h0000);
        wr(`IDX_POS_MODE, 16'h0004);
        cmd = 1'b1;
        tick(3);
        cmd = 1'b0;
        tick(3);
        chk(16'(pd), 16'h0000);
        tick(12);
        chk(16'(pd), 16'h0001);
        cmd = 1'b1;
        tick(3);
        chk(16'(pd), 16'h0000);
        wr(`IDX_POS_DELAY, 16'h0000);
        cmd = 1'b0;
        tick(3);
        chk(16'(pd), 16'h0001);
        tick(40);
        chk(16'(pd), 16'h0001);
        $display("test positioning done");
        rindex = `IDX_POS_WINDOW;
        wr(`IDX_POS_WINDOW, 16'h0030);
        chk(rdata, 16'h0030);
        i_sys_rst = 1'b1;
        tick(2);
        i_sys_rst = 1'b0;
        tick(1);
        chk(rdata, `RST_POS_WINDOW);
        chk(16'(outs), 16'h0000);
        $display("test reset in run done");
        final_report;
    end
endmodule // servo_status_output_mapper_tb_top
`default_nettype wire
